//--- hw/mps_seq.v
// Functional notes
// - store sixteen profiles of sixteen steps, executed in order.
// - four selector pins choose the profile; start pulse begins it.
// - each step holds control type/value, trigger type/value, action.
// - apply control and watch trigger; act only when trigger met.
// - control type is current, torque, velocity or position.
// - current mode commands the control value as current.
// - torque mode regulates torque to the control value until trigger.
// - velocity mode regulates speed to the control value until trigger.
// - velocity and position steps ramp speed with accel/decel rates.
// - position mode targets trigger value; control value limits speed.
// - position steps accept only absolute or incremental triggers.
// - stop-disable drops power stage; next start re-enables first.
// - zero-current stop ends profile with zero current command.
// - zero-velocity stop ends profile commanding zero speed.
// - hold stop ends profile holding the position at that moment.
// - next-step action advances and applies the following step; after step 15 it ends the profile.
// - no new selection is loaded while a profile runs.
// - start begins at the first step of the selected profile.
// - selector bits form profile number, bit3 first, with polarity.
// - time trigger met after trigger value seconds (ms units here).
// - absolute trigger met when encoder equals trigger value.
// - incremental trigger met after moving trigger value counts.
//
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`include "mps_seq_regs.vh"
module mps_seq #(
  parameter TICK_CYC = `MPS_TICK_CYC,
  parameter VW       = 32
) (
  input  wire          core_clk,           // control clock
  input  wire          arst_n,             // async reset, active low
  input  wire [3:0]    regAddr,            // register index
  input  wire [31:0]   regWdata,           // write data
  input  wire          regWr,              // write strobe
  input  wire          regRd,              // read strobe
  output reg  [31:0]   regRdata,           // read data, cycle after strobe
  input  wire          profile_select_bit0,// selector pin 0
  input  wire          profile_select_bit1,// selector pin 1
  input  wire          profile_select_bit2,// selector pin 2
  input  wire          profile_select_bit3,// selector pin 3
  input  wire          startPulse,         // profile start
  input  wire signed [VW-1:0] encCount,    // encoder count
  input  wire          torqueMet,          // torque trigger reached
  input  wire          analogMet,          // analog trigger reached
  input  wire          stepStopIn,         // digital input trigger
  output reg           driveEnable,        // power stage enable
  output reg  [1:0]    loopMode,           // active control loop
  output reg  signed [VW-1:0] cmdValue,    // current/torque command
  output reg  signed [VW-1:0] velCmd,      // ramped velocity command
  output reg  signed [VW-1:0] posTarget,   // position target
  output reg           running,            // profile executing
  output reg           stepFault           // bad trigger for position step
);
  // step store: index = profile*16 + step
  reg [VW-1:0] ctlMem  [0:255];
  reg [VW-1:0] trgMem  [0:255];
  reg [7:0]    typeMem [0:255];
  reg [7:0]    wAddr;
  reg [4:0]    ctrl;
  reg [VW-1:0] accel;
  reg [VW-1:0] decel;
  reg [3:0]    curProf;
  reg [3:0]    curStep;
  reg [1:0]    state;
  reg [31:0]   tickCnt;
  reg [31:0]   msCnt;
  reg signed [VW-1:0] stepStartPos;
  reg signed [VW-1:0] velGoal;
  reg          abortReq;
  localparam ST_IDLE = 2'h0;
  localparam ST_LOAD = 2'h1;
  localparam ST_RUN  = 2'h2;

  wire [3:0] selRaw = {profile_select_bit3, profile_select_bit2,
                       profile_select_bit1, profile_select_bit0};
  wire [3:0] selNum = selRaw ^ ctrl[`MPS_CTRL_POLMSB:`MPS_CTRL_POLLSB];
  wire [7:0] idx    = {curProf, curStep};
  wire [7:0] ty     = typeMem[idx];
  wire [1:0] ctlT   = ty[`MPS_TY_CTL_LSB+1:`MPS_TY_CTL_LSB];
  wire [2:0] trgT   = ty[`MPS_TY_TRG_LSB+2:`MPS_TY_TRG_LSB];
  wire [2:0] actT   = ty[`MPS_TY_ACT_LSB+2:`MPS_TY_ACT_LSB];
  wire signed [VW-1:0] ctlV = ctlMem[idx];
  wire signed [VW-1:0] trgV = trgMem[idx];
  wire signed [VW-1:0] moved = encCount - stepStartPos;
  wire signed [VW-1:0] absMoved = moved[VW-1] ? -moved : moved;
  wire signed [VW-1:0] absTrg = trgV[VW-1] ? -trgV : trgV;
  // position target of the step; the speed limit is signed toward it
  wire signed [VW-1:0] posGoal = (trgT == `MPS_TRG_ABS) ? trgV : encCount + trgV;
  wire posBad = (ctlT == `MPS_MODE_POS) &&
                (trgT != `MPS_TRG_ABS) && (trgT != `MPS_TRG_INC);
  reg  trigMet;

  always @*
  begin
    case (trgT)
      `MPS_TRG_TIME:   trigMet = (msCnt >= trgV);
      `MPS_TRG_TORQUE: trigMet = torqueMet;
      `MPS_TRG_ANALOG: trigMet = analogMet;
      `MPS_TRG_ABS:    trigMet = (encCount == trgV);
      `MPS_TRG_INC:    trigMet = (absMoved >= absTrg);
      `MPS_TRG_DIN:    trigMet = stepStopIn;
      default:         trigMet = 1'b0;
    endcase
  end

  // step store writes (no reset)
  always @(posedge core_clk)
  begin
    if (regWr && regAddr == `MPS_REG_WCTRL)
      ctlMem[wAddr] <= regWdata[VW-1:0];
    if (regWr && regAddr == `MPS_REG_WTRIG)
      trgMem[wAddr] <= regWdata[VW-1:0];
    if (regWr && regAddr == `MPS_REG_WTYPE)
      typeMem[wAddr] <= regWdata[7:0];
  end

  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wAddr    <= 8'h00;
      ctrl     <= `MPS_CTRL_RESET;
      accel    <= {VW{1'b0}};
      decel    <= {VW{1'b0}};
      regRdata <= 32'h0;
      abortReq <= 1'b0;
    end
    else
    begin
      abortReq <= regWr && regAddr == `MPS_REG_CTRL && regWdata[`MPS_CTRL_ABORT];
      if (regWr)
      begin
        case (regAddr)
          `MPS_REG_CTRL:  ctrl  <= {regWdata[4:1], 1'b0};
          `MPS_REG_WADDR: wAddr <= regWdata[7:0];
          `MPS_REG_ACCEL: accel <= regWdata[VW-1:0];
          `MPS_REG_DECEL: decel <= regWdata[VW-1:0];
          default:        wAddr <= wAddr;
        endcase
      end
      if (regRd)
      begin
        case (regAddr)
          `MPS_REG_CTRL:   regRdata <= {27'h0, ctrl};
          `MPS_REG_STATUS: regRdata <= {16'h0, curProf, curStep, 4'h0, stepFault, driveEnable, running, 1'b0};
          `MPS_REG_POS:    regRdata <= encCount;
          `MPS_REG_WADDR:  regRdata <= {24'h0, wAddr};
          `MPS_REG_ACCEL:  regRdata <= accel;
          `MPS_REG_DECEL:  regRdata <= decel;
          default:         regRdata <= 32'h0;
        endcase
      end
      else
        regRdata <= 32'h0;
    end
  end

  // sequencer
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state        <= ST_IDLE;
      curProf      <= 4'h0;
      curStep      <= 4'h0;
      running      <= 1'b0;
      driveEnable  <= 1'b0;
      loopMode     <= `MPS_MODE_CUR;
      cmdValue     <= {VW{1'b0}};
      velGoal      <= {VW{1'b0}};
      posTarget    <= {VW{1'b0}};
      stepStartPos <= {VW{1'b0}};
      tickCnt      <= 32'h0;
      msCnt        <= 32'h0;
      stepFault    <= 1'b0;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          if (startPulse)
          begin
            curProf     <= selNum;
            curStep     <= 4'h0;
            driveEnable <= 1'b1;
            running     <= 1'b1;
            stepFault   <= 1'b0;
            state       <= ST_LOAD;
          end
        end
        ST_LOAD:
        begin
          stepStartPos <= encCount;
          tickCnt      <= 32'h0;
          msCnt        <= 32'h0;
          loopMode     <= ctlT;
          if (abortReq)
            state <= ST_IDLE;
          else if (posBad)
          begin
            stepFault <= 1'b1;
            running   <= 1'b0;
            loopMode  <= `MPS_MODE_VEL;
            velGoal   <= {VW{1'b0}};
            state     <= ST_IDLE;
          end
          else
          begin
            case (ctlT)
              `MPS_MODE_CUR: cmdValue <= ctlV;
              `MPS_MODE_TRQ: cmdValue <= ctlV;
              `MPS_MODE_VEL: velGoal  <= ctlV;
              default:
              begin
                velGoal   <= (posGoal < encCount) ? -ctlV : ctlV;
                posTarget <= posGoal;
              end
            endcase
            state <= ST_RUN;
          end
        end
        ST_RUN:
        begin
          if (tickCnt == TICK_CYC - 1)
          begin
            tickCnt <= 32'h0;
            msCnt   <= msCnt + 32'h1;
          end
          else
            tickCnt <= tickCnt + 32'h1;
          if (abortReq)
            state <= ST_IDLE;
          else if (trigMet)
          begin
            case (actT)
              `MPS_ACT_NEXT:
              begin
                curStep <= curStep + 4'h1;
                state   <= ST_LOAD;
                if (curStep == 4'hf)
                begin
                  running <= 1'b0;
                  state   <= ST_IDLE;
                end
              end
              `MPS_ACT_DISABLE:
              begin
                driveEnable <= 1'b0;
                running     <= 1'b0;
                state       <= ST_IDLE;
              end
              `MPS_ACT_ZCUR:
              begin
                loopMode <= `MPS_MODE_CUR;
                cmdValue <= {VW{1'b0}};
                running  <= 1'b0;
                state    <= ST_IDLE;
              end
              `MPS_ACT_HOLD:
              begin
                loopMode  <= `MPS_MODE_POS;
                posTarget <= encCount;
                velGoal   <= {VW{1'b0}};
                running   <= 1'b0;
                state     <= ST_IDLE;
              end
              default:
              begin
                loopMode <= `MPS_MODE_VEL;
                velGoal  <= {VW{1'b0}};
                running  <= 1'b0;
                state    <= ST_IDLE;
              end
            endcase
          end
        end
        default: state <= ST_IDLE;
      endcase
      if (abortReq && state != ST_IDLE)
      begin
        running  <= 1'b0;
        loopMode <= `MPS_MODE_VEL;
        velGoal  <= {VW{1'b0}};
      end
    end
  end

  // velocity ramp toward goal, per clock
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      velCmd <= {VW{1'b0}};
    else if (loopMode == `MPS_MODE_VEL || loopMode == `MPS_MODE_POS)
    begin
      if (velCmd < velGoal)
        velCmd <= (velGoal - velCmd > accel) ? velCmd + accel : velGoal;
      else if (velCmd > velGoal)
        velCmd <= (velCmd - velGoal > decel) ? velCmd - decel : velGoal;
    end
    else
      velCmd <= {VW{1'b0}};
  end
endmodule // mps_seq

//--- hw/mps_seq_regs.vh
`ifndef MPS_SEQ_REGS_VH
`define MPS_SEQ_REGS_VH
// register indices (32-bit words, byte address = 4 * index)
`define MPS_REG_CTRL      4'h0
`define MPS_REG_STATUS    4'h1
`define MPS_REG_POS       4'h2
`define MPS_REG_WADDR     4'h3
`define MPS_REG_WCTRL     4'h4
`define MPS_REG_WTRIG     4'h5
`define MPS_REG_WTYPE     4'h6
`define MPS_REG_ACCEL     4'h7
`define MPS_REG_DECEL     4'h8
// ctrl register fields
`define MPS_CTRL_ABORT    0
`define MPS_CTRL_POLMSB   4
`define MPS_CTRL_POLLSB   1
`define MPS_CTRL_RESET    5'h00
// step type word fields
`define MPS_TY_CTL_LSB    0
`define MPS_TY_TRG_LSB    2
`define MPS_TY_ACT_LSB    5
// control modes
`define MPS_MODE_CUR      2'h0
`define MPS_MODE_TRQ      2'h1
`define MPS_MODE_VEL      2'h2
`define MPS_MODE_POS      2'h3
// trigger kinds
`define MPS_TRG_TIME      3'h0
`define MPS_TRG_TORQUE    3'h1
`define MPS_TRG_ANALOG    3'h2
`define MPS_TRG_ABS       3'h3
`define MPS_TRG_INC       3'h4
`define MPS_TRG_DIN       3'h5
// actions
`define MPS_ACT_DISABLE   3'h0
`define MPS_ACT_ZCUR      3'h1
`define MPS_ACT_ZVEL      3'h2
`define MPS_ACT_HOLD      3'h3
`define MPS_ACT_NEXT      3'h4
// timing
`define MPS_TICK_NS       1000000
`define MPS_CLK_NS        10
`define MPS_TICK_CYC      (`MPS_TICK_NS / `MPS_CLK_NS)
`define MPS_TICKS_PER_S   1000
`endif

//--- tb/mps_seq_monitor.sv
module mps_seq_monitor #(
  parameter VW = 32
) (
  input wire                 core_clk,    // clock
  input wire                 arst_n,      // reset
  input wire [3:0]           regAddr,     // index
  input wire [31:0]          regWdata,    // write data
  input wire                 regWr,       // write
  input wire                 regRd,       // read
  input wire [31:0]          regRdata,    // read data
  input wire                 startPulse,  // start
  input wire                 driveEnable, // power stage
  input wire [1:0]           loopMode,    // loop
  input wire signed [VW-1:0] velCmd,      // speed
  input wire                 running,     // busy
  input wire                 stepFault    // bad step
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // largest rate ever written, a safe bound on one ramp step
  logic signed [VW-1:0] rampLim;
  always @(posedge core_clk or negedge arst_n)
    if (!arst_n)
      rampLim <= '0;
    else if (regWr && (regAddr == 4'h7 || regAddr == 4'h8) && $signed(regWdata) > rampLim)
      rampLim <= $signed(regWdata);
  start_run_a: assert property (!running && startPulse |=> running && driveEnable)
    else $error("start not taken");
  run_cause_a: assert property ($rose(running) |-> $past(startPulse))
    else $error("run without start");
  idle_keep_a: assert property (!running && !startPulse |=> !running)
    else $error("run from nowhere");
  en_cause_a: assert property ($rose(driveEnable) |-> $past(startPulse) && !$past(running))
    else $error("enable without start");
  drive_on_a: assert property (running |-> driveEnable)
    else $error("running while disabled");
  abort_stop_a: assert property (running && regWr && regAddr == 4'h0 && regWdata[0] |-> ##[1:2] !running)
    else $error("abort ignored");
  fault_idle_a: assert property ($rose(stepFault) |-> !running)
    else $error("bad step still runs");
  vel_ramp_a: assert property (running && loopMode[1] ##1 running && loopMode[1] |->
    velCmd - $past(velCmd) <= rampLim && $past(velCmd) - velCmd <= rampLim) else $error("speed jump");
  rd_idle_a: assert property (!regRd |=> regRdata == 32'h0)
    else $error("read data outside slot");
  cover property ($rose(running));
  cover property ($rose(stepFault));
  cover property (running && loopMode == 2'h3);
endmodule // mps_seq_monitor

//--- tb/mps_motor_model.sv
module mps_motor_model #(
  parameter VW = 32
) (
  input  wire                  core_clk,    // clock
  input  wire                  arst_n,      // reset
  input  wire                  driveEnable, // power stage on
  input  wire signed [VW-1:0]  velCmd,      // speed command
  output logic signed [VW-1:0] encCount     // shaft position
);
  timeunit 1ns;
  timeprecision 1ps;
  // shaft moves by the speed command each cycle while powered
  always @(posedge core_clk or negedge arst_n)
    if (!arst_n)
      encCount <= '0;
    else if (driveEnable)
      encCount <= encCount + velCmd;
endmodule // mps_motor_model

//--- tb/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int VW = 32;
  logic core_clk = 0, arst_n = 0, regWr = 0, regRd = 0, startPulse = 0, rdFlag = 0;
  logic torqueMet = 0, analogMet = 0, stepStopIn = 0;
  logic profile_select_bit0 = 0, profile_select_bit1 = 0, profile_select_bit2 = 0, profile_select_bit3 = 0;
  logic [3:0]  regAddr = '0, pol = 4'hf;
  logic [31:0] regWdata = '0, expQ[$], mskQ[$];
  wire [31:0]  regRdata;
  wire [1:0]   loopMode;
  wire         driveEnable, running, stepFault;
  wire signed [VW-1:0] encCount, cmdValue, velCmd, posTarget;
  int bad_count = 0, checks = 0, n, p, rv, s;
  mps_seq #(.TICK_CYC(4), .VW(VW)) uut (.*);
  mps_motor_model #(.VW(VW)) motor (.*);
  initial forever #5 core_clk = ~core_clk;
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tk(int c);
    repeat (c) @(negedge core_clk);
  endtask
  task automatic wr(logic [3:0] a, logic [31:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1;
    regRd <= 0;
    @(posedge core_clk);
    regWr <= 0;
  endtask
  task automatic rd(logic [3:0] a, logic [31:0] e, logic [31:0] m);
    @(posedge core_clk);
    regAddr <= a;
    regRd <= 1;
    regWr <= 0;
    expQ.push_back(e & m);
    mskQ.push_back(m);
    @(posedge core_clk);
    regRd <= 0;
  endtask
  task automatic store(int pr, int st, logic [1:0] md, logic [31:0] cv, logic [2:0] tg, logic [31:0] tv,
                       logic [2:0] ac);
    wr(4'h3, pr * 16 + st);
    wr(4'h4, cv);
    wr(4'h5, tv);
    wr(4'h6, {24'h0, ac, tg, md});
  endtask
  task automatic go(int pr);
    @(posedge core_clk);
    regWr <= 0;
    regRd <= 0;
    {profile_select_bit3, profile_select_bit2, profile_select_bit1, profile_select_bit0} <= pr[3:0] ^ pol;
    startPulse <= 1;
    @(posedge core_clk);
    startPulse <= 0;
  endtask
  task automatic complete_run();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge core_clk) rdFlag <= regRd;
  always @(negedge core_clk)
    if (rdFlag)
      chk("regRdata", expQ.pop_front(), regRdata & mskQ.pop_front());
  initial
  begin
    tk(20000);
    bad_count++;
    complete_run();
  end
  initial
  begin
    void'($urandom(72608));
    p = $urandom_range(15);
    rv = $urandom_range(1000, 1);
    tk(5);
    @(posedge core_clk) arst_n <= 1;
    wr(4'h0, 32'h1e);
    wr(4'h7, 32'h4);
    wr(4'h8, 32'h4);
    store(p, 0, 2'h0, rv, 3'h0, 2, 3'h4);
    store(p, 1, 2'h1, rv + 1, 3'h1, 0, 3'h4);
    store(p, 2, 2'h0, rv + 2, 3'h2, 0, 3'h4);
    store(p, 3, 2'h2, 40, 3'h5, 0, 3'h2);
    go(p);
    tk(2);
    chk("loopMode", 0, loopMode);
    chk("cmdValue", rv, cmdValue);
    for (n = 0; n < 100 && cmdValue !== rv + 1; n++) tk(1);
    chk("timeWait", 1, n >= 5);
    chk("cmdValue", rv + 1, cmdValue);
    chk("loopMode", 1, loopMode);
    go(p ^ 5);
    tk(3);
    chk("cmdValue", rv + 1, cmdValue);
    @(posedge core_clk) torqueMet <= 1;
    tk(3);
    chk("cmdValue", rv + 2, cmdValue);
    @(posedge core_clk) analogMet <= 1;
    tk(3);
    chk("loopMode", 2, loopMode);
    for (n = 0; n < 100 && velCmd !== 40; n++) tk(1);
    chk("velCmd", 40, velCmd);
    chk("rampWait", 1, n >= 5);
    @(posedge core_clk) stepStopIn <= 1;
    for (n = 0; n < 100 && velCmd !== 0; n++) tk(1);
    chk("velCmd", 0, velCmd);
    chk("running", 0, running);
    pol = 4'h0;
    s = encCount;
    wr(4'h0, 32'h0);
    wr(4'h7, 32'h1);
    wr(4'h8, 32'h1);
    store(p ^ 8, 0, 2'h3, 1, 3'h4, 12, 3'h4);
    store(p ^ 8, 1, 2'h3, 1, 3'h3, s + 5, 3'h3);
    @(posedge core_clk) stepStopIn <= 0;
    go(p ^ 8);
    tk(2);
    chk("posTarget", s + 12, posTarget);
    chk("loopMode", 3, loopMode);
    for (n = 0; n < 200 && posTarget !== s + 5; n++) tk(1);
    chk("incMoved", 1, encCount - s >= 12);
    for (n = 0; n < 200 && running === 1'b1; n++) tk(1);
    chk("posTarget", s + 5, posTarget);
    chk("loopMode", 3, loopMode);
    store(p ^ 2, 0, 2'h3, 1, 3'h0, 2, 3'h4);
    go(p ^ 2);
    tk(3);
    chk("stepFault", 1, stepFault);
    chk("running", 0, running);
    rd(4'h1, 32'h8, 32'ha);
    rd(4'hf, 32'h0, 32'hffffffff);
    store(p ^ 4, 0, 2'h0, 7, 3'h5, 0, 3'h0);
    store(p ^ 6, 0, 2'h1, 11, 3'h0, 200, 3'h4);
    @(posedge core_clk) stepStopIn <= 1;
    go(p ^ 4);
    tk(3);
    chk("driveEnable", 0, driveEnable);
    chk("running", 0, running);
    go(p ^ 6);
    tk(2);
    chk("driveEnable", 1, driveEnable);
    chk("cmdValue", 11, cmdValue);
    wr(4'h0, 32'h1);
    tk(3);
    chk("running", 0, running);
    chk("loopMode", 2, loopMode);
    go(p ^ 6);
    tk(2);
    chk("running", 1, running);
    chk("cmdValue", 11, cmdValue);
    wr(4'h0, 32'h1);
    tk(3);
    store(p ^ 7, 0, 2'h0, 5, 3'h5, 0, 3'h1);
    go(p ^ 7);
    tk(3);
    chk("cmdValue", 0, cmdValue);
    chk("running", 0, running);
    tk(3);
    complete_run();
  end
endmodule // tb_top
bind mps_seq mps_seq_monitor #(.VW(VW)) mon (.*);
